/* File: design/frame_timer.sv */
// lcd frame timing with master sync pulse and slave alignment
`timescale 1ns/1ps
module frame_timer (
  input  wire logic       i_mclk,
  input  wire logic       i_rst_n,
  input  wire logic       i_ce,
  input  wire logic       i_master,
  input  wire logic       i_div16,
  input  wire logic       i_sync_in,
  output logic            o_sync_pulse,
  output logic      [3:0] o_row_idx,
  output logic            o_lcd_ac
);

  typedef struct packed {
    logic [7:0] tick;
    logic [3:0] row;
    logic       ac;
    logic       pulse;
    logic       sync_prev;
  } ft_state_t;

  ft_state_t q;
  ft_state_t d;
  logic [3:0] row_last;
  logic       frame_end;

  // ----------------------------------------------------------------
  // counters
  // ----------------------------------------------------------------
  always_comb
  begin
    row_last  = i_div16 ? lcd_host_pkg::ROWS_LAST_DIV16 : lcd_host_pkg::ROWS_LAST_DIV8;
    frame_end = (q.tick == lcd_host_pkg::ROW_TICK_LAST) && (q.row == row_last);
    d = q;
    d.sync_prev = i_sync_in;
    if (q.tick == lcd_host_pkg::ROW_TICK_LAST)
    begin
      d.tick = 8'h00;
      d.row  = frame_end ? 4'h0 : q.row + 4'h1;
      d.ac   = frame_end ? ~q.ac : q.ac;
    end
    else
    begin
      d.tick = q.tick + 8'h01;
    end
    // slave: the pulse marks the master's last cycle, so restart at frame start (row 0, tick 0, ac toggled)
    if (!i_master && i_sync_in && !q.sync_prev)
    begin
      d.tick = 8'h00;
      d.row  = 4'h0;
      d.ac   = ~q.ac;
    end
    d.pulse = i_master && (d.tick == lcd_host_pkg::ROW_TICK_LAST) && (d.row == row_last);
  end

  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_n)
      q <= '0;
    else if (i_ce)
      q <= d;
  end

  assign o_sync_pulse = q.pulse;
  assign o_row_idx    = q.row;
  assign o_lcd_ac     = q.ac;

endmodule : frame_timer

/* File: design/lcd_host_if.sv */
// host interface of the lcd controller: parallel/serial port, busy, modes
`timescale 1ns/1ps
module lcd_host_if (
  input  wire logic       i_mclk,
  input  wire logic       i_rst_n,
  input  wire logic       i_ce,
  // host pins
  input  wire logic       i_strobe_in,
  input  wire logic       i_cs_n,
  input  wire logic       i_cmd_data,
  input  wire logic [3:0] i_data_pin,
  output logic      [3:0] o_data_pin,
  output logic      [3:0] o_data_oe_n,
  output logic            o_busy_n,
  output logic            o_busy_oe_n,
  input  wire logic       i_chip_addr_bit0,
  input  wire logic       i_chip_addr_bit1,
  // frame sync pin
  input  wire logic       i_sync_pin,
  output logic            o_sync_pin,
  output logic            o_sync_oe_n,
  // command decoder side
  output logic            o_cmd_valid,
  output logic      [7:0] o_cmd_byte,
  input  wire logic       i_dp_mode_set,
  input  wire logic [2:0] i_dp_mode,
  input  wire logic       i_disp_mode_set,
  input  wire logic       i_sync_master,
  input  wire logic       i_row_upper,
  input  wire logic       i_shared_as_rows,
  input  wire logic       i_div16,
  input  wire logic       i_core_done,
  // character generator
  output logic            o_char_valid,
  output logic      [7:0] o_char_code,
  // display memory
  output logic            o_mem_rd,
  input  wire logic       i_mem_rvalid,
  input  wire logic [7:0] i_mem_rdata,
  output logic            o_mem_wr,
  output logic      [7:0] o_mem_wdata,
  // display mode and status
  output logic            o_row_upper,
  output logic            o_shared_as_rows,
  output logic      [3:0] o_row_idx,
  output logic            o_lcd_ac,
  output logic            o_par_mode,
  output logic            o_addr_en
);

  typedef struct packed {
    logic                      par;
    logic                      cae;
    logic                      stb_prev;
    logic [3:0]                cnt;
    logic [7:0]                rx;
    logic [7:0]                hold;
    logic                      busy;
    lcd_host_pkg::proc_state_t st;
    logic                      addr_phase;
    logic                      sel_ok;
    lcd_host_pkg::dp_mode_t    mode;
    logic                      prefetched;
    logic                      mem_rd;
    logic                      mem_wr;
    logic [7:0]                wdata;
    logic                      cmd_valid;
    logic                      char_valid;
    logic [7:0]                code;
    logic [3:0]                dout;
    logic                      master;
    logic                      row_upper;
    logic                      shared_rows;
    logic                      div16;
  } host_state_t;

  host_state_t q;
  host_state_t d;

  logic [lcd_host_pkg::SYNC_W-1:0] sy;
  logic                            stb;
  logic                            cs_n;
  logic                            cd;
  logic [3:0]                      din;
  logic [1:0]                      strap;
  logic                            fsync_in;
  logic                            fsync_pulse;
  logic                            addr_en;
  logic                            selected;
  logic                            accept;
  logic                            rise;
  logic                            fall;
  logic                            last;
  logic [7:0]                      new_byte;

  // ----------------------------------------------------------------
  // decoding helpers
  // ----------------------------------------------------------------
  function automatic logic is_last_beat(input logic par, input logic [3:0] cnt);
    is_last_beat = par ? (cnt == lcd_host_pkg::LAST_NIBBLE)
                       : (cnt == lcd_host_pkg::LAST_BIT);
  endfunction : is_last_beat

  function automatic logic is_read(input lcd_host_pkg::dp_mode_t mode);
    is_read = (mode == lcd_host_pkg::DP_READ);
  endfunction : is_read

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  pin_sync #(
    .WIDTH (lcd_host_pkg::SYNC_W)
  ) u_sync (
    .i_mclk  (i_mclk),
    .i_rst_n (i_rst_n),
    .i_ce    (i_ce),
    .i_async ({i_sync_pin, i_chip_addr_bit1, i_chip_addr_bit0, i_data_pin,
               i_cmd_data, i_cs_n, i_strobe_in}),
    .o_sync  (sy)
  );

  assign stb      = sy[lcd_host_pkg::SY_STB];
  assign cs_n     = sy[lcd_host_pkg::SY_CS];
  assign cd       = sy[lcd_host_pkg::SY_CD];
  assign din      = sy[lcd_host_pkg::SY_D0 +: 4];
  assign strap    = sy[lcd_host_pkg::SY_CA0 +: 2];
  assign fsync_in = sy[lcd_host_pkg::SY_FSYNC];

  // ----------------------------------------------------------------
  // frame timing
  // ----------------------------------------------------------------
  frame_timer u_frame (
    .i_mclk       (i_mclk),
    .i_rst_n      (i_rst_n),
    .i_ce         (i_ce),
    .i_master     (q.master),
    .i_div16      (q.div16),
    .i_sync_in    (fsync_in),
    .o_sync_pulse (fsync_pulse),
    .o_row_idx    (o_row_idx),
    .o_lcd_ac     (o_lcd_ac)
  );

  // ----------------------------------------------------------------
  // selection
  // ----------------------------------------------------------------
  always_comb
  begin
    addr_en  = q.par | q.cae;
    selected = !cs_n && (!addr_en || q.sel_ok);
    accept   = !cs_n && !q.busy && (!addr_en || q.addr_phase || q.sel_ok);
    rise     = stb && !q.stb_prev;
    fall     = !stb && q.stb_prev;
    last     = is_last_beat(q.par, q.cnt);
    new_byte = q.par ? {q.rx[7:4], din} : {q.rx[6:0], din[lcd_host_pkg::PIN_SI]};
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    d = q;
    d.stb_prev   = stb;
    d.mem_rd     = 1'b0;
    d.mem_wr     = 1'b0;
    d.cmd_valid  = 1'b0;
    d.char_valid = 1'b0;

    if (i_dp_mode_set)
    begin
      d.mode       = lcd_host_pkg::dp_mode_t'(i_dp_mode);
      d.prefetched = 1'b0;
    end
    if (i_disp_mode_set)
    begin
      d.master      = i_sync_master;
      d.row_upper   = i_row_upper;
      d.shared_rows = i_shared_as_rows;
      d.div16       = i_div16;
    end

    // internal processing
    case (q.st)
      lcd_host_pkg::ST_IDLE:
      begin
        if (is_read(q.mode) && !q.prefetched && !i_dp_mode_set && q.cnt == 4'h0)
        begin
          d.mem_rd = 1'b1;
          d.busy   = 1'b1;
          d.st     = lcd_host_pkg::ST_MEMRD;
        end
      end
      lcd_host_pkg::ST_MEMRD:
      begin
        if (i_mem_rvalid)
        begin
          d.st = lcd_host_pkg::ST_FINISH;
          case (q.mode)
            lcd_host_pkg::DP_AND:
            begin
              d.wdata  = q.rx & i_mem_rdata;
              d.mem_wr = 1'b1;
            end
            lcd_host_pkg::DP_OR:
            begin
              d.wdata  = q.rx | i_mem_rdata;
              d.mem_wr = 1'b1;
            end
            default:
            begin
              d.hold       = i_mem_rdata;
              d.prefetched = 1'b1;
            end
          endcase
        end
      end
      lcd_host_pkg::ST_CORE:
      begin
        if (i_core_done)
          d.st = lcd_host_pkg::ST_FINISH;
      end
      lcd_host_pkg::ST_FINISH:
      begin
        d.busy = 1'b0;
        d.st   = lcd_host_pkg::ST_IDLE;
      end
      default:
      begin
        d.busy = 1'b0;
        d.st   = lcd_host_pkg::ST_IDLE;
      end
    endcase

    // byte transfer
    if (cs_n)
    begin
      d.cnt        = 4'h0;
      d.addr_phase = addr_en;
      d.sel_ok     = 1'b0;
    end
    else if (rise && accept)
    begin
      if (q.par && q.cnt == 4'h0)
        d.rx[7:4] = din;
      else if (!q.par)
        d.rx = new_byte;
      d.cnt = last ? 4'h0 : q.cnt + 4'h1;
      if (last)
      begin
        d.rx = new_byte;
        if (q.addr_phase)
        begin
          d.addr_phase = 1'b0;
          d.sel_ok = (new_byte[lcd_host_pkg::ADDR_LSB +: lcd_host_pkg::ADDR_W] == strap);
        end
        else
        begin
          d.busy = 1'b1;
          if (cd)
          begin
            d.cmd_valid = 1'b1;
            d.code      = new_byte;
            d.st        = lcd_host_pkg::ST_CORE;
          end
          else
          begin
            case (q.mode)
              lcd_host_pkg::DP_WRITE:
              begin
                d.wdata  = new_byte;
                d.mem_wr = 1'b1;
                d.st     = lcd_host_pkg::ST_FINISH;
              end
              lcd_host_pkg::DP_CHAR:
              begin
                d.char_valid = 1'b1;
                d.code       = new_byte;
                d.st         = lcd_host_pkg::ST_CORE;
              end
              default:
              begin
                d.mem_rd = 1'b1;
                d.st     = lcd_host_pkg::ST_MEMRD;
              end
            endcase
          end
        end
      end
    end
    else if (fall && accept && is_read(q.mode))
    begin
      if (q.par)
        d.dout = (q.cnt == 4'h0) ? q.hold[7:4] : q.hold[3:0];
      else
        d.dout[lcd_host_pkg::PIN_SO] = q.hold[3'(lcd_host_pkg::LAST_BIT - q.cnt)];
    end

    // straps are caught every cycle of reset, so the last one before release wins
    if (!i_rst_n)
    begin
      d = '0;
      d.mode       = lcd_host_pkg::RST_DP_MODE;
      d.st         = lcd_host_pkg::ST_IDLE;
      d.par        = din[lcd_host_pkg::PIN_PS];
      d.cae        = !din[lcd_host_pkg::PIN_PS] && din[lcd_host_pkg::PIN_CAE];
      d.addr_phase = 1'b1;
      // idle strobe level, so no false rise follows release
      d.stb_prev   = stb;
    end
  end

  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_n || i_ce)
      q <= d;
  end

  // ----------------------------------------------------------------
  // pin drivers
  // ----------------------------------------------------------------
  always_comb
  begin
    o_data_oe_n = 4'hf;
    if (selected && is_read(q.mode))
    begin
      if (q.par)
        o_data_oe_n = 4'h0;
      else
        o_data_oe_n[lcd_host_pkg::PIN_SO] = 1'b0;
    end
  end

  assign o_data_pin       = q.dout;
  assign o_busy_n         = !q.busy;
  assign o_busy_oe_n      = !selected;
  assign o_sync_pin       = fsync_pulse;
  assign o_sync_oe_n      = !q.master;
  assign o_cmd_valid      = q.cmd_valid;
  assign o_cmd_byte       = q.code;
  assign o_char_valid     = q.char_valid;
  assign o_char_code      = q.code;
  assign o_mem_rd         = q.mem_rd;
  assign o_mem_wr         = q.mem_wr;
  assign o_mem_wdata      = q.wdata;
  assign o_row_upper      = q.row_upper;
  assign o_shared_as_rows = q.shared_rows;
  assign o_par_mode       = q.par;
  assign o_addr_en        = addr_en;

endmodule : lcd_host_if

/* File: design/pin_sync.sv */
// two flip-flop synchroniser for a vector of pin inputs
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             i_mclk,
  input  wire logic             i_rst_n,
  input  wire logic             i_ce,
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);

  // ----------------------------------------------------------------
  // per-bit stages
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++)
    begin : g_bit
      logic meta_q;
      logic stab_q;
      always_ff @(posedge i_mclk)
      begin
        // runs through reset so the straps reach the core before release
        if (!i_rst_n || i_ce)
        begin
          meta_q <= i_async[g];
          stab_q <= meta_q;
        end
      end
      assign o_sync[g] = stab_q;
    end
  endgenerate

endmodule : pin_sync

/* File: dv/host_cpu_model.sv */
// host processor model: strobe or serial clock, select and data pins
`timescale 1ns/1ps
module host_cpu_model (
  input  wire logic       i_mclk,
  input  wire logic [3:0] i_pin,
  output logic            o_stb,
  output logic            o_cs_n,
  output logic            o_cd,
  output logic      [3:0] o_pin
);
  // ----------------------------------------
  // transfers, strobe idles high between them
  // ----------------------------------------
  initial
  begin
    o_stb = 1'b1;
    o_cs_n = 1'b1;
    o_cd = 1'b0;
    o_pin = 4'h0;
  end
  task automatic sel(input logic v);
    @(negedge i_mclk);
    o_cs_n = v;
    repeat (8) @(negedge i_mclk);
  endtask : sel
  // n units of a byte, msb first; read data sampled just before each rise
  task automatic xfer(input logic par, input logic cd, input logic [7:0] b, input int n,
                      output logic [7:0] r);
    r = 8'h00;
    @(negedge i_mclk);
    o_cd = cd;
    for (int i = 0; i < n; i++)
    begin
      o_stb = 1'b0;
      o_pin = par ? (i[0] ? b[3:0] : b[7:4]) : {~o_pin[3], 2'b00, b[7 - i]};
      repeat (8) @(negedge i_mclk);
      r = par ? {r[3:0], i_pin} : {r[6:0], i_pin[3]};
      o_stb = 1'b1;
      repeat (8) @(negedge i_mclk);
    end
  endtask : xfer
endmodule : host_cpu_model

/* File: dv/lcd_host_if_bench.sv */
// self-checking bench of the lcd host interface
`timescale 1ns/1ps
module lcd_host_if_bench;
  logic i_mclk = 1'b0, i_rst_n = 1'b0, i_ce = 1'b1, i_sync_pin = 1'b0, par = 1'b0;
  logic i_chip_addr_bit0 = 1'b0, i_chip_addr_bit1 = 1'b0, i_dp_mode_set = 1'b0;
  logic i_disp_mode_set = 1'b0, i_sync_master = 1'b0, i_row_upper = 1'b0, i_div16 = 1'b0;
  logic i_shared_as_rows = 1'b0, i_core_done = 1'b0, i_mem_rvalid = 1'b0;
  logic i_strobe_in, i_cs_n, i_cmd_data, o_busy_n, o_busy_oe_n, o_sync_pin, o_sync_oe_n;
  logic o_cmd_valid, o_char_valid, o_mem_rd, o_mem_wr, o_row_upper, o_shared_as_rows;
  logic o_lcd_ac, o_par_mode, o_addr_en;
  logic [2:0] i_dp_mode = 3'h0;
  logic [3:0] i_data_pin, o_data_pin, o_data_oe_n, o_row_idx, hpin;
  logic [7:0] i_mem_rdata = 8'h00, o_cmd_byte, o_char_code, o_mem_wdata, b, r, m;
  logic [7:0] wq[$], cq[$], mq[$];
  logic [1:0] ca;
  int n_errors = 0, n_compared = 0, k;
  always #2.5 i_mclk = ~i_mclk;
  lcd_host_if lcd_host_if_inst (.i_mclk, .i_rst_n, .i_ce, .i_strobe_in, .i_cs_n, .i_cmd_data,
    .i_data_pin, .o_data_pin, .o_data_oe_n, .o_busy_n, .o_busy_oe_n, .i_chip_addr_bit0,
    .i_chip_addr_bit1, .i_sync_pin, .o_sync_pin, .o_sync_oe_n, .o_cmd_valid, .o_cmd_byte,
    .i_dp_mode_set, .i_dp_mode, .i_disp_mode_set, .i_sync_master, .i_row_upper,
    .i_shared_as_rows, .i_div16, .i_core_done, .o_char_valid, .o_char_code, .o_mem_rd,
    .i_mem_rvalid, .i_mem_rdata, .o_mem_wr, .o_mem_wdata, .o_row_upper, .o_shared_as_rows,
    .o_row_idx, .o_lcd_ac, .o_par_mode, .o_addr_en);
  host_cpu_model host_cpu_model_inst (.i_mclk, .i_pin(i_data_pin), .o_stb(i_strobe_in),
    .o_cs_n(i_cs_n), .o_cd(i_cmd_data), .o_pin(hpin));
  assign i_data_pin = (o_data_pin & ~o_data_oe_n) | (hpin & o_data_oe_n);
  // ----------------------------------------
  // decoder and memory stand-ins, result log
  // ----------------------------------------
  always @(negedge i_mclk)
  begin
    i_core_done <= o_cmd_valid | o_char_valid;
    i_mem_rvalid <= o_mem_rd;
    if (o_mem_rd)
    begin
      m = 8'($urandom);
      mq.push_back(m);
      i_mem_rdata <= m;
    end
  end
  always @(posedge i_mclk)
  begin
    if (o_mem_wr) wq.push_back(o_mem_wdata);
    if (o_cmd_valid) cq.push_back(o_cmd_byte);
    if (o_char_valid) cq.push_back(o_char_code);
  end
  function automatic logic [7:0] expw(input int md, input logic [7:0] v);
    logic [7:0] x;
    x = (md == 0) ? v : mq.pop_front();
    return (md == 1) ? (v & x) : (v | x);
  endfunction : expw
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      n_errors++;
      $display("unexpected at %0t ns: got %h, expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic print_verdict();
    if (n_errors == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : print_verdict
  task automatic idle();
    repeat (6) @(negedge i_mclk);
    for (int i = 0; i < 500 && !(o_busy_oe_n || o_busy_n); i++) @(negedge i_mclk);
    chk(o_busy_n | o_busy_oe_n, 1'b1);
  endtask : idle
  task automatic put(input logic c, input logic [7:0] v, input int n);
    host_cpu_model_inst.xfer(par, c, v, n, r);
    idle();
  endtask : put
  task automatic rst(input logic p, input logic cae, input logic [1:0] a);
    host_cpu_model_inst.sel(1'b1);
    par = p;
    {i_chip_addr_bit1, i_chip_addr_bit0} = a;
    host_cpu_model_inst.o_pin = {1'b0, cae, p, 1'b0};
    i_rst_n = 1'b0;
    repeat (6) @(negedge i_mclk);
    i_rst_n = 1'b1;
    repeat (4) @(negedge i_mclk);
    wq.delete();
    mq.delete();
    cq.delete();
    chk(o_par_mode, p);
    chk(o_addr_en, p | cae);
    chk(o_busy_oe_n, 1'b1);
  endtask : rst
  task automatic mode(input int md);
    @(negedge i_mclk);
    i_dp_mode = 3'(md);
    i_dp_mode_set = 1'b1;
    @(negedge i_mclk);
    i_dp_mode_set = 1'b0;
    idle();
  endtask : mode
  task automatic dset(input logic ms, input logic d16);
    @(negedge i_mclk);
    i_sync_master = ms;
    i_div16 = d16;
    i_row_upper = 1'($urandom);
    i_shared_as_rows = 1'($urandom);
    i_disp_mode_set = 1'b1;
    @(negedge i_mclk);
    i_disp_mode_set = 1'b0;
    repeat (2) @(negedge i_mclk);
    chk(o_row_upper, i_row_upper);
    chk(o_shared_as_rows, i_shared_as_rows);
    chk(o_sync_oe_n, !ms);
  endtask : dset
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial
  begin
    repeat (100000) @(posedge i_mclk);
    n_errors++;
    print_verdict();
  end
  initial
  begin
    void'($urandom(32'h6b7dfaff));
    rst(1'b0, 1'b1, 2'b00);
    rst(1'b0, 1'b0, 2'b00);
    host_cpu_model_inst.sel(1'b0);
    b = 8'($urandom);
    put(1'b0, b, 8);
    chk(wq.pop_front(), b);
    for (k = 0; k < 3; k++)
    begin
      b = 8'($urandom);
      put(1'b1, b, 8);
      chk(cq.pop_front(), b);
    end
    for (k = 0; k < 4; k++)
    begin
      mode(k);
      b = 8'($urandom);
      put(1'b0, b, 8);
      if (k == 3) chk(cq.pop_front(), b);
      else chk(wq.pop_front(), expw(k, b));
    end
    mode(0);
    host_cpu_model_inst.xfer(par, 1'b0, 8'h5a, 3, r);
    host_cpu_model_inst.sel(1'b1);
    host_cpu_model_inst.xfer(par, 1'b0, 8'ha5, 8, r);
    host_cpu_model_inst.sel(1'b0);
    b = 8'($urandom);
    put(1'b0, b, 8);
    chk(wq.size(), 1);
    chk(wq.pop_front(), b);
    mode(4);
    for (k = 0; k < 2; k++)
    begin
      put(1'b0, 8'h00, 8);
      chk(r, mq.pop_front());
    end
    ca = 2'($urandom);
    rst(1'b1, 1'b0, ca);
    host_cpu_model_inst.sel(1'b0);
    put(1'b0, {6'h00, ~ca}, 2);
    put(1'b0, 8'h3c, 2);
    chk(o_busy_oe_n, 1'b1);
    chk(wq.size(), 0);
    host_cpu_model_inst.sel(1'b1);
    host_cpu_model_inst.sel(1'b0);
    put(1'b0, {6'h00, ca}, 2);
    b = 8'($urandom);
    put(1'b0, b, 2);
    chk(wq.pop_front(), b);
    mode(4);
    put(1'b0, 8'h00, 2);
    chk(r, mq.pop_front());
    for (int d = 0; d < 2; d++)
    begin
      dset(1'b1, d[0]);
      for (k = 0; k < 4000 && o_sync_pin !== 1'b1; k++) @(negedge i_mclk);
      @(negedge i_mclk);
      for (k = 1; k < 8000 && o_sync_pin !== 1'b1; k++) @(negedge i_mclk);
      chk(16'(k), 16'(lcd_host_pkg::ROW_TICKS * (d == 1 ? 16 : 8)));
      chk(o_row_idx, (d == 1) ? 4'hf : 4'h7);
    end
    dset(1'b0, 1'b0);
    for (k = 0; k < 4000 && o_row_idx != 4'h3; k++) @(negedge i_mclk);
    b[0] = o_lcd_ac;
    i_sync_pin = 1'b1;
    repeat (4) @(negedge i_mclk);
    i_sync_pin = 1'b0;
    chk(o_row_idx, 4'h0);
    chk(o_lcd_ac, !b[0]);
    i_ce = 1'b0;
    repeat (300) @(negedge i_mclk);
    i_ce = 1'b1;
    chk(o_row_idx, 4'h0);
    print_verdict();
  end
endmodule : lcd_host_if_bench

/* File: dv/lcd_host_monitor.sv */
// port checker of the lcd host interface
`timescale 1ns/1ps
module lcd_host_monitor (
  input wire logic       i_mclk,
  input wire logic       i_rst_n,
  input wire logic       i_cs_n,
  input wire logic       i_core_done,
  input wire logic       i_mem_rvalid,
  input wire logic       i_disp_mode_set,
  input wire logic       i_sync_master,
  input wire logic [3:0] o_data_oe_n,
  input wire logic       o_busy_n,
  input wire logic       o_busy_oe_n,
  input wire logic       o_mem_wr,
  input wire logic       o_mem_rd,
  input wire logic       o_cmd_valid,
  input wire logic       o_char_valid,
  input wire logic       o_sync_pin,
  input wire logic       o_sync_oe_n
);
  // ----------------------------------------
  // port relations
  // ----------------------------------------
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_rst_n);
  cs_float_a: assert property (i_cs_n [*4] |-> o_busy_oe_n && o_data_oe_n == 4'hf)
    else $error("pins driven while deselected");
  wr_pulse_a: assert property (o_mem_wr |=> !o_mem_wr)
    else $error("memory write longer than one cycle");
  cmd_busy_a: assert property (o_cmd_valid || o_char_valid |-> !o_busy_n)
    else $error("byte handed on without busy");
  rd_busy_a: assert property (o_mem_rd |-> !o_busy_n)
    else $error("memory fetch without busy");
  done_free_a: assert property (!o_busy_n && i_core_done |-> ##2 o_busy_n)
    else $error("busy held after processing done");
  rd_free_a: assert property (!o_busy_n && i_mem_rvalid |-> ##2 o_busy_n)
    else $error("busy held after memory answer");
  sync_out_a: assert property (i_disp_mode_set && i_sync_master |-> ##[1:2] !o_sync_oe_n)
    else $error("master sync pin not driven");
  sync_in_a: assert property (i_disp_mode_set && !i_sync_master |-> ##[1:2] o_sync_oe_n)
    else $error("slave sync pin driven");
  sync_pulse_a: assert property (o_sync_pin |-> !o_sync_oe_n ##1 !o_sync_pin)
    else $error("sync pulse malformed");
  cover property (o_mem_wr);
  cover property (o_char_valid);
  cover property (o_mem_rd);
  cover property (o_sync_pin);
endmodule : lcd_host_monitor
bind lcd_host_if lcd_host_monitor lcd_host_monitor_inst (.i_mclk, .i_rst_n, .i_cs_n,
  .i_core_done, .i_mem_rvalid, .i_disp_mode_set, .i_sync_master, .o_data_oe_n, .o_busy_n,
  .o_busy_oe_n, .o_mem_wr, .o_mem_rd, .o_cmd_valid, .o_char_valid, .o_sync_pin, .o_sync_oe_n);

/* File: pkg/lcd_host_pkg.sv */
// shared constants and types of the lcd controller host interface
package lcd_host_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 5000;
  localparam int ROW_TIME_NS   = 1000;
  localparam int ROW_TICKS_INT = (ROW_TIME_NS * 1000) / CLK_PERIOD_PS;
  localparam int ROW_TICKS     = (ROW_TICKS_INT < 1) ? 1 : ROW_TICKS_INT;
  localparam logic [7:0] ROW_TICK_LAST = 8'(ROW_TICKS - 1);

  // ----------------------------------------------------------------
  // transfer framing
  // ----------------------------------------------------------------
  localparam logic [3:0] LAST_NIBBLE     = 4'h1;
  localparam logic [3:0] LAST_BIT        = 4'h7;
  localparam logic [3:0] ROWS_LAST_DIV8  = 4'hf & 4'h7;
  localparam logic [3:0] ROWS_LAST_DIV16 = 4'hf;
  localparam int         ADDR_LSB        = 0;
  localparam int         ADDR_W          = 2;

  // ----------------------------------------------------------------
  // data pin roles
  // ----------------------------------------------------------------
  localparam int PIN_SI  = 0;
  localparam int PIN_PS  = 1;
  localparam int PIN_CAE = 2;
  localparam int PIN_SO  = 3;

  // ----------------------------------------------------------------
  // synchroniser vector layout
  // ----------------------------------------------------------------
  localparam int SY_STB   = 0;
  localparam int SY_CS    = 1;
  localparam int SY_CD    = 2;
  localparam int SY_D0    = 3;
  localparam int SY_CA0   = 7;
  localparam int SY_FSYNC = 9;
  localparam int SYNC_W   = 10;

  // ----------------------------------------------------------------
  // modes and states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    DP_WRITE = 3'h0,
    DP_AND   = 3'h1,
    DP_OR    = 3'h2,
    DP_CHAR  = 3'h3,
    DP_READ  = 3'h4
  } dp_mode_t;

  localparam dp_mode_t RST_DP_MODE = DP_WRITE;

  typedef enum logic [1:0] {
    ST_IDLE   = 2'h0,
    ST_MEMRD  = 2'h1,
    ST_CORE   = 2'h3,
    ST_FINISH = 2'h2
  } proc_state_t;

endpackage : lcd_host_pkg
